/* File: rtl/spo_register_map.sv */
`timescale 1ns/1ps

module spo_register_map #(
  parameter int SHED_TICK_CYCLES = spo_pkg::CLK_HZ / int'(spo_pkg::TICKS_PER_SECOND)
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // host request and answer
  input wire spo_pkg::spo_req_s req_i,
  output spo_pkg::spo_rsp_s rsp_o,
  // configuration from the rest of the controller
  input wire logic [15:0] shed_time_i,
  input wire logic monitor_mode_req_i,
  input wire spo_pkg::spo_status_s status_i,
  // controller side
  output logic [31:0] host_override_value_o,
  output logic override_active_o,
  output logic keypad_locked_o,
  output logic two_setpoints_o,
  output logic nvm_write_o
);
  import spo_pkg::*;

  initial begin
    if (SHED_TICK_CYCLES < 1) begin
      $error("SHED_TICK_CYCLES must be at least one");
    end
  end

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    spo_rsp_s rsp;
    spo_mode_e mode;
    logic [31:0] sp_low;
    logic [31:0] sp_high;
    logic [31:0] sp_one;
    logic [31:0] sp_two;
    logic [31:0] ratio;
    logic [31:0] bias;
    logic [31:0] host_sp;
    logic [31:0] override_out;
    logic [15:0] sp_count;
    logic [31:0] tick_cnt;
    logic [31:0] shed_cnt;
    logic nvm_write;
  } spo_state_s;

  spo_state_s st;
  spo_state_s next_st;

  // ratio and bias on raw 32-bit words; float arithmetic lives in the controller core
  function automatic logic [31:0] apply_ratio_bias(input logic [31:0] v, input logic [31:0] r,
                                                   input logic [31:0] b);
    logic [63:0] prod;
    prod = 64'(v) * 64'(r);
    return prod[31:0] + b;
  endfunction : apply_ratio_bias

  function automatic logic [31:0] clamp(input logic [31:0] v, input logic [31:0] lo,
                                        input logic [31:0] hi);
    logic [31:0] r;
    r = v;
    if (v < lo) begin
      r = lo;
    end
    if (v > hi) begin
      r = hi;
    end
    return r;
  endfunction : clamp

  function automatic logic is_read_only(input logic [15:0] a);
    return a == REG_FIRMWARE_TYPE || a == REG_FIRMWARE_REV || a == REG_OPTION_BITMAP ||
           (a >= REG_PROG_SEGMENT && a <= REG_PROG_CYCLE_INDEX);
  endfunction : is_read_only

  logic shed_on;
  logic wr;
  logic clear_hit;
  logic [31:0] shed_limit;

  assign shed_on = shed_time_i != SHED_DISABLED;
  assign wr = req_i.valid && req_i.write;
  // code 6 on the integer alias, code 21 on the float alias; data unused
  assign clear_hit = wr && ((req_i.func == FC_WRITE_SINGLE && req_i.addr == REG_SHED_CLEAR_INT) ||
                            (req_i.func == FC_WRITE_FILE && req_i.addr == REG_SHED_CLEAR_FP));
  assign shed_limit = 32'(shed_time_i) * 32'(TICKS_PER_SECOND);

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_st = st;
    next_st.rsp = '0;
    next_st.nvm_write = 1'b0;
    next_st.override_out = clamp(apply_ratio_bias(st.host_sp, st.ratio, st.bias),
                                 st.sp_low, st.sp_high);

    // shed timer runs only while in slave mode with a nonzero shed time
    if (st.mode == SPO_SLAVE && shed_on) begin
      if (st.tick_cnt >= 32'(SHED_TICK_CYCLES - 1)) begin
        next_st.tick_cnt = '0;
        next_st.shed_cnt = st.shed_cnt + 32'd1;
      end else begin
        next_st.tick_cnt = st.tick_cnt + 32'd1;
      end
      if (st.shed_cnt >= shed_limit) begin
        next_st.mode = SPO_SHED;
      end
    end

    if (req_i.valid) begin
      next_st.rsp.valid = 1'b1;
      // any host traffic except infrared refreshes the shed interval
      if (!req_i.infrared) begin
        next_st.tick_cnt = '0;
        next_st.shed_cnt = '0;
      end
      if (!req_i.write) begin
        unique case (req_i.addr)
          REG_SP_LOW_LIMIT: next_st.rsp.data = st.sp_low;
          REG_SP_HIGH_LIMIT: next_st.rsp.data = st.sp_high;
          REG_LOCAL_SP_ONE: next_st.rsp.data = st.sp_one;
          REG_LOCAL_SP_TWO: next_st.rsp.data = st.sp_two;
          REG_HOST_SP_RATIO: next_st.rsp.data = st.ratio;
          REG_HOST_SP_BIAS: next_st.rsp.data = st.bias;
          REG_HOST_OVERRIDE_SP: next_st.rsp.data = st.host_sp;
          REG_LOCAL_SP_COUNT: next_st.rsp.data = {16'h0000, st.sp_count};
          REG_OPTION_BITMAP: next_st.rsp.data = {24'h000000, status_i.option_bitmap};
          REG_FIRMWARE_TYPE: next_st.rsp.data = {16'h0000, status_i.firmware_type};
          REG_FIRMWARE_REV: next_st.rsp.data = {16'h0000, status_i.firmware_rev};
          REG_PROG_SEGMENT: next_st.rsp.data = {16'h0000, status_i.segment};
          REG_SEG_MINUTES: next_st.rsp.data = {16'h0000, status_i.minutes_left};
          REG_SEG_HOURS: next_st.rsp.data = {16'h0000, status_i.hours_left};
          REG_PROG_CYCLES_LEFT: next_st.rsp.data = {16'h0000, status_i.cycles_left};
          REG_PROG_CYCLE_INDEX: next_st.rsp.data = {16'h0000, status_i.cycle_index};
          default: next_st.rsp.exception = 1'b1;
        endcase
      end else if (is_read_only(req_i.addr)) begin
        next_st.rsp.exception = 1'b1;
      end else if (clear_hit) begin
        next_st.mode = SPO_MONITOR;
      end else begin
        unique case (req_i.addr)
          REG_SP_LOW_LIMIT: next_st.sp_low = req_i.data;
          REG_SP_HIGH_LIMIT: next_st.sp_high = req_i.data;
          REG_LOCAL_SP_ONE: next_st.sp_one = clamp(req_i.data, st.sp_low, st.sp_high);
          REG_LOCAL_SP_TWO: next_st.sp_two = clamp(req_i.data, st.sp_low, st.sp_high);
          REG_HOST_SP_RATIO: next_st.ratio = req_i.data;
          REG_HOST_SP_BIAS: next_st.bias = req_i.data;
          REG_HOST_OVERRIDE_SP: next_st.host_sp = req_i.data;
          REG_LOCAL_SP_COUNT: begin
            if (req_i.data[15:0] == COUNT_ONE_ONLY || req_i.data[15:0] == COUNT_TWO) begin
              next_st.sp_count = req_i.data[15:0];
            end else begin
              next_st.rsp.exception = 1'b1;
            end
          end
          default: next_st.rsp.exception = 1'b1;
        endcase
        // nonvolatile writeback for configuration, never for the host setpoint
        next_st.nvm_write = !next_st.rsp.exception &&
                            req_i.addr != REG_HOST_OVERRIDE_SP;
        if (!next_st.rsp.exception && shed_on && !req_i.infrared) begin
          next_st.mode = SPO_SLAVE;
        end
      end
    end

    if (monitor_mode_req_i || !shed_on) begin
      next_st.mode = SPO_MONITOR;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '{rsp: '0, mode: SPO_MONITOR, sp_low: FP_ZERO, sp_high: FP_ZERO, sp_one: FP_ZERO,
              sp_two: FP_ZERO, ratio: FP_ONE, bias: FP_ZERO, host_sp: FP_ZERO,
              override_out: FP_ZERO, sp_count: COUNT_ONE_ONLY, tick_cnt: '0, shed_cnt: '0,
              nvm_write: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign rsp_o = st.rsp;
  assign host_override_value_o = st.override_out;
  assign override_active_o = st.mode == SPO_SLAVE;
  assign keypad_locked_o = st.mode == SPO_SLAVE;
  assign two_setpoints_o = st.sp_count == COUNT_TWO;
  assign nvm_write_o = st.nvm_write;

  // ****************************************
  // checks
  // ****************************************
  chk_ro_write_refused: assert property (@(posedge clk_i) disable iff (rst_i)
    (req_i.valid && req_i.write && is_read_only(req_i.addr)) |=> rsp_o.exception)
    else $error("write to read-only register not refused");
  chk_fw_rev_kept: assert property (@(posedge clk_i) disable iff (rst_i)
    (req_i.valid && req_i.write && req_i.addr == REG_FIRMWARE_REV) |=> !nvm_write_o)
    else $error("firmware revision write was accepted");
  chk_shed_off_monitor: assert property (@(posedge clk_i) disable iff (rst_i)
    (shed_time_i == SHED_DISABLED) |=> !keypad_locked_o)
    else $error("slave mode while shed disabled");
  chk_write_enters_slave: assert property (@(posedge clk_i) disable iff (rst_i)
    (req_i.valid && req_i.write && req_i.addr == REG_HOST_OVERRIDE_SP && !req_i.infrared &&
     shed_time_i != SHED_DISABLED && !monitor_mode_req_i) |=> keypad_locked_o)
    else $error("host write did not enter slave mode");
  chk_clear_exits_slave: assert property (@(posedge clk_i) disable iff (rst_i)
    (req_i.valid && req_i.write && req_i.func == FC_WRITE_SINGLE &&
     req_i.addr == REG_SHED_CLEAR_INT) |=> !override_active_o)
    else $error("shed timer reset did not exit slave mode");
  chk_host_sp_volatile: assert property (@(posedge clk_i) disable iff (rst_i)
    (req_i.valid && req_i.write && req_i.addr == REG_HOST_OVERRIDE_SP) |=> !nvm_write_o)
    else $error("host setpoint started a nonvolatile write");
  chk_option_range: assert property (@(posedge clk_i) disable iff (rst_i)
    (req_i.valid && !req_i.write && req_i.addr == REG_OPTION_BITMAP) |=>
      (rsp_o.valid && rsp_o.data <= 32'(OPTION_MAX)))
    else $error("option bitmap read out of range");
  chk_count_honoured: assert property (@(posedge clk_i) disable iff (rst_i)
    (req_i.valid && req_i.write && req_i.addr == REG_LOCAL_SP_COUNT &&
     req_i.data[15:0] == COUNT_TWO) |=> two_setpoints_o)
    else $error("second local setpoint not enabled");
  chk_monitor_ends: assert property (@(posedge clk_i) disable iff (rst_i)
    monitor_mode_req_i |=> !override_active_o)
    else $error("override survived monitor mode request");

  // ****************************************
  // answer, mode, setpoint count and nonvolatile write checks
  // ****************************************
  chk_rsp_follows_req: assert property (@(posedge clk_i) disable iff (rst_i)
    req_i.valid |=> rsp_o.valid)
    else $error("request got no answer");
  chk_rsp_only_after: assert property (@(posedge clk_i) disable iff (rst_i)
    !req_i.valid |=> !rsp_o.valid)
    else $error("answer without request");
  chk_exc_zero_data: assert property (@(posedge clk_i) disable iff (rst_i)
    rsp_o.exception |-> rsp_o.data == FP_ZERO)
    else $error("exception answer carries data");
  chk_wo_read_refused: assert property (@(posedge clk_i) disable iff (rst_i)
    (req_i.valid && !req_i.write && req_i.addr == REG_SHED_CLEAR_INT) |=> rsp_o.exception)
    else $error("read of write-only register not refused");
  chk_fw_type_read: assert property (@(posedge clk_i) disable iff (rst_i)
    (req_i.valid && !req_i.write && req_i.addr == REG_FIRMWARE_TYPE) |=>
      (rsp_o.data == {16'h0000, $past(status_i.firmware_type)}))
    else $error("firmware type read wrong");
  chk_fw_type_kept: assert property (@(posedge clk_i) disable iff (rst_i)
    (req_i.valid && req_i.write && req_i.addr == REG_FIRMWARE_TYPE) |=> !nvm_write_o)
    else $error("firmware type write was accepted");
  chk_ro_no_slave: assert property (@(posedge clk_i) disable iff (rst_i)
    (req_i.valid && req_i.write && is_read_only(req_i.addr) && !override_active_o) |=>
      !override_active_o)
    else $error("refused write entered slave mode");
  chk_segment_read: assert property (@(posedge clk_i) disable iff (rst_i)
    (req_i.valid && !req_i.write && req_i.addr == REG_PROG_SEGMENT) |=>
      (rsp_o.valid && !rsp_o.exception))
    else $error("segment read refused");
  chk_cycle_index_read: assert property (@(posedge clk_i) disable iff (rst_i)
    (req_i.valid && !req_i.write && req_i.addr == REG_PROG_CYCLE_INDEX) |=>
      (rsp_o.data == {16'h0000, $past(status_i.cycle_index)}))
    else $error("cycle index read wrong");
  chk_count_one: assert property (@(posedge clk_i) disable iff (rst_i)
    (req_i.valid && req_i.write && req_i.addr == REG_LOCAL_SP_COUNT &&
     req_i.data[15:0] == COUNT_ONE_ONLY) |=> !two_setpoints_o)
    else $error("single local setpoint not selected");
  chk_count_refused: assert property (@(posedge clk_i) disable iff (rst_i)
    (req_i.valid && req_i.write && req_i.addr == REG_LOCAL_SP_COUNT &&
     req_i.data[15:0] > COUNT_TWO) |=> (rsp_o.exception && $stable(two_setpoints_o)))
    else $error("bad setpoint count accepted");
  chk_host_sp_taken: assert property (@(posedge clk_i) disable iff (rst_i)
    (req_i.valid && req_i.write && req_i.addr == REG_HOST_OVERRIDE_SP) |=> !rsp_o.exception)
    else $error("host setpoint write refused");
  chk_read_no_slave: assert property (@(posedge clk_i) disable iff (rst_i)
    (req_i.valid && !req_i.write && !override_active_o) |=> !override_active_o)
    else $error("read entered slave mode");
  chk_shed_zero_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    (shed_time_i == SHED_DISABLED) |=> !override_active_o)
    else $error("override active with shed time zero");
  chk_clear_fp_exits: assert property (@(posedge clk_i) disable iff (rst_i)
    (req_i.valid && req_i.write && req_i.func == FC_WRITE_FILE &&
     req_i.addr == REG_SHED_CLEAR_FP) |=> !override_active_o)
    else $error("float shed reset did not exit slave mode");
  chk_clear_no_nvm: assert property (@(posedge clk_i) disable iff (rst_i)
    clear_hit |=> !nvm_write_o)
    else $error("shed reset started a nonvolatile write");
  chk_clear_no_exc: assert property (@(posedge clk_i) disable iff (rst_i)
    clear_hit |=> !rsp_o.exception)
    else $error("shed reset answered with exception");
  chk_ir_write_no_slave: assert property (@(posedge clk_i) disable iff (rst_i)
    (req_i.valid && req_i.write && req_i.infrared && !override_active_o) |=>
      !override_active_o)
    else $error("infrared write entered slave mode");
  chk_monitor_unlocks: assert property (@(posedge clk_i) disable iff (rst_i)
    monitor_mode_req_i |=> !keypad_locked_o)
    else $error("keypad locked in monitor mode");
  chk_nvm_needs_write: assert property (@(posedge clk_i) disable iff (rst_i)
    !(req_i.valid && req_i.write) |=> !nvm_write_o)
    else $error("nonvolatile write without host write");
  chk_config_nvm: assert property (@(posedge clk_i) disable iff (rst_i)
    (req_i.valid && req_i.write && req_i.addr == REG_SP_LOW_LIMIT) |=> nvm_write_o)
    else $error("configuration write not stored");
  chk_ro_read_ok: assert property (@(posedge clk_i) disable iff (rst_i)
    (req_i.valid && !req_i.write && req_i.addr == REG_OPTION_BITMAP) |=> !rsp_o.exception)
    else $error("option bitmap read refused");

endmodule : spo_register_map

/* File: common/spo_pkg.sv */
package spo_pkg;

  // ****************************************
  // register numbers
  // ****************************************
  localparam logic [15:0] REG_SP_LOW_LIMIT = 16'h0007;
  localparam logic [15:0] REG_SP_HIGH_LIMIT = 16'h0008;
  localparam logic [15:0] REG_LOCAL_SP_ONE = 16'h0027;
  localparam logic [15:0] REG_LOCAL_SP_TWO = 16'h0035;
  localparam logic [15:0] REG_HOST_SP_RATIO = 16'h005A;
  localparam logic [15:0] REG_HOST_SP_BIAS = 16'h005B;
  localparam logic [15:0] REG_HOST_OVERRIDE_SP = 16'h007D;
  localparam logic [15:0] REG_SHED_CLEAR_FP = 16'h007F;
  localparam logic [15:0] REG_FIRMWARE_TYPE = 16'h009D;
  localparam logic [15:0] REG_FIRMWARE_REV = 16'h00A7;
  localparam logic [15:0] REG_LOCAL_SP_COUNT = 16'h00AD;
  localparam logic [15:0] REG_OPTION_BITMAP = 16'h00B9;
  localparam logic [15:0] REG_PROG_SEGMENT = 16'h00FB;
  localparam logic [15:0] REG_SEG_MINUTES = 16'h00FC;
  localparam logic [15:0] REG_SEG_HOURS = 16'h00FD;
  localparam logic [15:0] REG_PROG_CYCLES_LEFT = 16'h00FE;
  localparam logic [15:0] REG_PROG_CYCLE_INDEX = 16'h00FF;
  localparam logic [15:0] REG_SHED_CLEAR_INT = 16'h1B90;

  // ****************************************
  // function codes and limits
  // ****************************************
  localparam logic [7:0] FC_WRITE_SINGLE = 8'h06;
  localparam logic [7:0] FC_WRITE_FILE = 8'h15;
  localparam logic [15:0] COUNT_ONE_ONLY = 16'h0000;
  localparam logic [15:0] COUNT_TWO = 16'h0001;
  localparam logic [15:0] OPTION_MAX = 16'h00FF;
  localparam logic [15:0] SEGMENT_MIN = 16'h0001;
  localparam logic [15:0] SEGMENT_MAX = 16'h000C;
  localparam logic [15:0] MINUTES_MAX = 16'h003B;
  localparam logic [15:0] HOURS_MAX = 16'h0063;
  localparam logic [15:0] CYCLES_MAX = 16'h0064;
  localparam logic [15:0] SHED_DISABLED = 16'h0000;
  localparam logic [31:0] FP_ZERO = 32'h0000_0000;
  localparam logic [31:0] FP_ONE = 32'h3F80_0000;
  localparam logic [15:0] TICKS_PER_SECOND = 16'd10;
  localparam int CLK_HZ = 100_000_000;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [2:0] {
    SPO_MONITOR = 3'b001,
    SPO_SLAVE = 3'b010,
    SPO_SHED = 3'b100
  } spo_mode_e;

  typedef struct packed {
    logic valid;
    logic write;
    logic infrared;
    logic [7:0] func;
    logic [15:0] addr;
    logic [31:0] data;
  } spo_req_s;

  typedef struct packed {
    logic valid;
    logic exception;
    logic [31:0] data;
  } spo_rsp_s;

  typedef struct packed {
    logic [7:0] option_bitmap;
    logic [15:0] firmware_type;
    logic [15:0] firmware_rev;
    logic [15:0] segment;
    logic [15:0] minutes_left;
    logic [15:0] hours_left;
    logic [15:0] cycles_left;
    logic [15:0] cycle_index;
  } spo_status_s;

endpackage : spo_pkg

/* File: verif/spo_host_model.sv */
`timescale 1ns/1ps
module spo_host_model
  import spo_pkg::*;
(
  // clock
  input wire logic clk_i,
  // request and answer
  output spo_pkg::spo_req_s req_o,
  input wire spo_pkg::spo_rsp_s rsp_i
);
  initial req_o = '0;
  // one request; the answer is taken one edge after the request edge
  task automatic xfer(input logic wr, input logic ir, input logic [7:0] fc,
                      input logic [15:0] a, input logic [31:0] d, output spo_rsp_s r);
    @(posedge clk_i);
    req_o <= '{valid: 1'b1, write: wr, infrared: ir, func: fc, addr: a, data: d};
    @(posedge clk_i);
    // idle lines other than infrared show the inverse so a stale value never looks valid
    req_o <= '{valid: 1'b0, write: ~wr, infrared: ir, func: ~fc, addr: ~a, data: ~d};
    #1;
    r = rsp_i;
  endtask : xfer
endmodule : spo_host_model

/* File: verif/setpoint_override_register_map_tb.sv */
`timescale 1ns/1ps
module setpoint_override_register_map_tb;
  import spo_pkg::*;
  // ****************************************
  // bench signals
  // ****************************************
  typedef struct packed {
    logic wr;
    logic [15:0] a;
    logic exc;
    logic [31:0] q;
  } spo_row_s;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [15:0] shed_time = 16'h0000;
  logic mon_req = 1'b0;
  // type code value is arbitrary
  spo_status_s status = '{8'hA5, 16'h0042, 16'h00FE, 16'h000C, 16'h003B, 16'h0063,
                          16'h0064, 16'h0000};
  spo_req_s req;
  spo_rsp_s rsp;
  spo_rsp_s r;
  logic [31:0] sp_val;
  logic active, locked, two_sp, nvm;
  int n_fail = 0;
  int tests_run = 0;
  int nvm_cnt = 0;
  int k;
  spo_row_s rows [14];

  spo_register_map #(.SHED_TICK_CYCLES(4)) dut (.clk_i(clk_i), .rst_i(rst_i), .req_i(req),
    .rsp_o(rsp), .shed_time_i(shed_time), .monitor_mode_req_i(mon_req), .status_i(status),
    .host_override_value_o(sp_val), .override_active_o(active), .keypad_locked_o(locked),
    .two_setpoints_o(two_sp), .nvm_write_o(nvm));
  spo_host_model host (.clk_i(clk_i), .req_o(req), .rsp_i(rsp));

  initial begin
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    if (nvm === 1'b1) nvm_cnt++;
  end

  // ****************************************
  // helpers
  // ****************************************
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    host.xfer(1'b1, 1'b0, FC_WRITE_SINGLE, a, d, r);
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic ir);
    host.xfer(1'b0, ir, 8'h03, a, 32'h0, r);
  endtask : rd
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    #200000;
    n_fail++;
    tally_and_finish();
  end

  // ****************************************
  // tests
  // ****************************************
  initial begin
    rows = '{'{0, 16'h00B9, 0, 32'hA5}, '{0, 16'h009D, 0, 32'h42}, '{0, 16'h00A7, 0, 32'hFE},
             '{0, 16'h00FB, 0, 32'h0C}, '{0, 16'h00FC, 0, 32'h3B}, '{0, 16'h00FD, 0, 32'h63},
             '{0, 16'h00FE, 0, 32'h64}, '{0, 16'h00FF, 0, 32'h00}, '{1, 16'h009D, 1, 32'h0},
             '{1, 16'h00B9, 1, 32'h0}, '{1, 16'h00FF, 1, 32'h0}, '{0, 16'h0200, 1, 32'h0},
             '{1, 16'h00AD, 1, 32'h0}, '{0, 16'h00AD, 0, 32'h0}};
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    #1;
    check({rsp.valid, active, locked, two_sp, nvm}, 40'h0);
    rd(REG_HOST_SP_RATIO, 1'b0);
    check(r.data, FP_ONE);
    $display("test reset done");
    foreach (rows[i]) begin
      // the count row writes 2, which is out of range
      host.xfer(rows[i].wr, 1'b0, rows[i].wr ? FC_WRITE_SINGLE : 8'h03, rows[i].a, 32'h2, r);
      check({r.valid, r.exception, r.data}, {1'b1, rows[i].exc, rows[i].q});
    end
    check(nvm_cnt, 0);
    $display("test table done");
    wr(REG_LOCAL_SP_COUNT, {16'h0, COUNT_TWO});
    check(two_sp, 1);
    wr(REG_LOCAL_SP_COUNT, {16'h0, COUNT_ONE_ONLY});
    check(two_sp, 0);
    wr(REG_SP_LOW_LIMIT, 32'd10);
    wr(REG_SP_HIGH_LIMIT, 32'd1000);
    wr(REG_HOST_SP_RATIO, 32'd2);
    wr(REG_HOST_SP_BIAS, 32'd5);
    wr(REG_LOCAL_SP_ONE, 32'd50);
    rd(REG_LOCAL_SP_ONE, 1'b0);
    check(r.data, 32'd50);
    k = nvm_cnt;
    check(k > 0, 1);
    wr(REG_HOST_OVERRIDE_SP, 32'd100);
    repeat (3) @(posedge clk_i);
    check({active, nvm_cnt}, {1'b0, k});
    $display("test monitor done");
    @(posedge clk_i);
    shed_time <= 16'h0001;
    wr(REG_HOST_OVERRIDE_SP, 32'd100);
    check({active, locked}, 2'b11);
    @(posedge clk_i);
    #1;
    check(sp_val, 32'd100 * 2 + 32'd5);
    wr(REG_HOST_OVERRIDE_SP, 32'd600);
    @(posedge clk_i);
    #1;
    check(sp_val, 32'd1000);
    repeat (6) begin
      repeat (20) @(posedge clk_i);
      rd(REG_OPTION_BITMAP, 1'b0);
    end
    check(active, 1);
    repeat (4) begin
      repeat (20) @(posedge clk_i);
      rd(REG_OPTION_BITMAP, 1'b1);
    end
    check({active, locked}, 2'b00);
    $display("test shed done");
    for (int i = 0; i < 2; i++) begin
      wr(REG_HOST_OVERRIDE_SP, 32'd100);
      check(active, 1);
      host.xfer(1'b1, 1'b0, i ? FC_WRITE_FILE : FC_WRITE_SINGLE,
                i ? REG_SHED_CLEAR_FP : REG_SHED_CLEAR_INT, 32'hDEAD_BEEF + i, r);
      @(posedge clk_i);
      #1;
      check({r.exception, active, nvm_cnt}, {2'b00, k});
    end
    host.xfer(1'b1, 1'b0, 8'h10, REG_SHED_CLEAR_INT, 32'h0, r);
    check(r.exception, 1);
    $display("test clear done");
    wr(REG_HOST_OVERRIDE_SP, 32'd100);
    @(posedge clk_i);
    mon_req <= 1'b1;
    repeat (2) @(posedge clk_i);
    #1;
    check(active, 0);
    @(posedge clk_i);
    mon_req <= 1'b0;
    shed_time <= 16'h0000;
    wr(REG_HOST_OVERRIDE_SP, 32'd100);
    repeat (60) @(posedge clk_i);
    check(active, 0);
    $display("test mode done");
    tally_and_finish();
  end
endmodule : setpoint_override_register_map_tb
